// file: hw/link_pkg.sv
// shared constants for the narrow parallel link between phy and mac
// ---------------------------------------------------------------------
// ---------------------------------------------------------------------
package link_pkg;
  localparam int LANES = 3;
  localparam int WORD_BEATS = 4;
  localparam int WORD_W = LANES * WORD_BEATS;
  localparam int FIFO_DEPTH = 4;
  localparam int SYS_CLK_KHZ = 200000;
  // link clock frequencies in khz
  localparam int LCLK_GIG_KHZ = 62500;
  localparam int LCLK_100_KHZ = 50000;
  localparam int LCLK_10_KHZ = 5000;
  // half periods in system cycles, rounded down, at least one
  localparam int HALF_GIG = SYS_CLK_KHZ / (2 * LCLK_GIG_KHZ);
  localparam int HALF_100 = SYS_CLK_KHZ / (2 * LCLK_100_KHZ);
  localparam int HALF_10 = SYS_CLK_KHZ / (2 * LCLK_10_KHZ);
  localparam int HALF_W = 8;
  localparam int RESET_HOLD_US = 500;
  localparam int RESET_HOLD_CYC = RESET_HOLD_US * (SYS_CLK_KHZ / 1000);
  localparam logic [1:0] SPEED_10 = 2'h0;
  localparam logic [1:0] SPEED_100 = 2'h1;
  localparam logic [1:0] SPEED_GIG = 2'h2;
endpackage

// file: hw/link_if.sv
// pin bundle of the narrow parallel link
`timescale 1ns/100ps
interface link_if;
  logic link_clock_out;
  logic reset_sync_in;
  logic [2:0] mac_to_phy_lane;
  logic [2:0] phy_to_mac_lane;
  modport phy (output link_clock_out, output phy_to_mac_lane,
               input reset_sync_in, input mac_to_phy_lane);
  modport mac (input link_clock_out, input phy_to_mac_lane,
               output reset_sync_in, output mac_to_phy_lane);
endinterface

// file: hw/word_fifo.sv
// small valid/ready fifo
`timescale 1ns/100ps
module word_fifo #(
  parameter int WIDTH = 12,
  parameter int DEPTH = 4
) (
  // clock and reset
  input wire logic clock_i,
  input wire logic nrst_i,
  input wire logic ce_i,
  // fill side
  input wire logic in_valid_i,
  output logic in_ready_o,
  input wire logic [WIDTH-1:0] in_data_i,
  // drain side
  output logic out_valid_o,
  input wire logic out_ready_i,
  output logic [WIDTH-1:0] out_data_o
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_r [DEPTH];
  logic [AW-1:0] wp_r, wp_nxt, rp_r, rp_nxt;
  logic [AW:0] cnt_r, cnt_nxt;
  logic push, pop;
  assign in_ready_o = cnt_r != (AW+1)'(DEPTH);
  assign out_valid_o = cnt_r != '0;
  assign out_data_o = mem_r[rp_r];
  always_comb begin
    push = in_valid_i && (cnt_r != (AW+1)'(DEPTH));
    pop = out_ready_i && (cnt_r != '0);
    wp_nxt = push ? AW'(wp_r + 1'b1) : wp_r;
    rp_nxt = pop ? AW'(rp_r + 1'b1) : rp_r;
    cnt_nxt = cnt_r + (AW+1)'(push) - (AW+1)'(pop);
  end
  always_ff @(posedge clock_i) begin
    if (!nrst_i) begin
      wp_r <= '0;
      rp_r <= '0;
      cnt_r <= '0;
    end else if (ce_i) begin
      wp_r <= wp_nxt;
      rp_r <= rp_nxt;
      cnt_r <= cnt_nxt;
      if (push) begin
        mem_r[wp_r] <= in_data_i;
      end
    end
  end
endmodule

// file: hw/phy_link_end.sv
// phy end of the narrow link: clock source, reset/sync, lane framing
`timescale 1ns/100ps
module phy_link_end
  import link_pkg::*;
#(
  parameter int RESET_HOLD = link_pkg::RESET_HOLD_CYC
) (
  // clock and reset
  input wire logic clock_i,
  input wire logic nrst_i,
  input wire logic ce_i,
  // link pins
  link_if.phy lnk,
  // user side
  input wire logic [1:0] speed_i,
  input wire logic power_down_i,
  input wire logic tx_valid_i,
  output logic tx_ready_o,
  input wire logic [link_pkg::WORD_W-1:0] tx_data_i,
  output logic rx_valid_o,
  output logic [link_pkg::WORD_W-1:0] rx_data_o,
  output logic link_reset_o,
  output logic powered_down_o
);
  import link_pkg::*;
  typedef enum logic [2:0] {
    ST_RUN = 3'b001,
    ST_DOWN = 3'b010,
    ST_RESET = 3'b100
  } pstate_t;
  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  pstate_t st_r, st_nxt;
  logic [HALF_W-1:0] div_r, div_nxt, half;
  logic clk_r, clk_nxt;
  logic rs_s1_r, rs_s2_r, rs_d_r;
  logic [2:0] ln_s1_r, ln_s2_r;
  logic [1:0] beat_r, beat_nxt, tbeat_r, tbeat_nxt;
  logic [WORD_W-1:0] sh_r, sh_nxt, tsh_r, tsh_nxt;
  logic [2:0] out_r, out_nxt;
  logic rvalid_r, rvalid_nxt;
  logic [WORD_W-1:0] rdata_r, rdata_nxt;
  logic [1:0] hi_r, hi_nxt;
  logic [31:0] hold_r, hold_nxt;
  logic rise, fall, f_ready, f_valid, f_pop;
  logic [WORD_W-1:0] f_data;
  word_fifo #(.WIDTH(WORD_W), .DEPTH(FIFO_DEPTH)) tx_fifo (
    .clock_i(clock_i), .nrst_i(nrst_i), .ce_i(ce_i),
    .in_valid_i(tx_valid_i), .in_ready_o(f_ready),
    .in_data_i(tx_data_i),
    .out_valid_o(f_valid), .out_ready_i(f_pop), .out_data_o(f_data)
  );
  always_comb begin
    case (speed_i)
      SPEED_GIG: half = HALF_W'(HALF_GIG);
      SPEED_100: half = HALF_W'(HALF_100);
      default: half = HALF_W'(HALF_10);
    endcase
  end
  // ---------------------------------------------------------------
  // clock divider, reset/sync and power state
  // ---------------------------------------------------------------
  always_comb begin
    div_nxt = div_r;
    clk_nxt = clk_r;
    rise = 1'b0;
    fall = 1'b0;
    if (st_r == ST_RUN) begin
      if (div_r >= half - 1'b1) begin
        div_nxt = '0;
        clk_nxt = !clk_r;
        rise = !clk_r;
        fall = clk_r;
      end else begin
        div_nxt = div_r + 1'b1;
      end
    end else begin
      div_nxt = '0;
      clk_nxt = 1'b0;
    end
  end
  always_comb begin
    st_nxt = st_r;
    hi_nxt = hi_r;
    hold_nxt = hold_r;
    // high counted in link cycles only while the clock runs
    if (!rs_s2_r) begin
      hi_nxt = '0;
    end else if (rise && hi_r != 2'h3) begin
      hi_nxt = hi_r + 1'b1;
    end
    // while stopped, measure the level in system cycles instead
    if (rs_s2_r) begin
      hold_nxt = (hold_r == 32'hffffffff) ? hold_r : hold_r + 1'b1;
    end else begin
      hold_nxt = '0;
    end
    case (st_r)
      ST_RUN: begin
        if (hi_r >= 2'h2) begin
          st_nxt = ST_RESET;
        end else if (power_down_i) begin
          st_nxt = ST_DOWN;
        end
      end
      ST_DOWN: begin
        if (hold_r >= 32'(HALF_10 * 4)) begin
          st_nxt = ST_RESET;
        end
      end
      ST_RESET: begin
        if (!rs_s2_r && !power_down_i) begin
          st_nxt = ST_RUN;
        end
      end
      default: st_nxt = ST_RESET;
    endcase
  end
  // ---------------------------------------------------------------
  // lane framing
  // ---------------------------------------------------------------
  always_comb begin
    beat_nxt = beat_r;
    sh_nxt = sh_r;
    rvalid_nxt = 1'b0;
    rdata_nxt = rdata_r;
    tbeat_nxt = tbeat_r;
    tsh_nxt = tsh_r;
    out_nxt = out_r;
    f_pop = 1'b0;
    if (st_r != ST_RUN) begin
      beat_nxt = '0;
      tbeat_nxt = '0;
      out_nxt = '0;
    end else begin
      if (rise) begin
        sh_nxt = {sh_r[WORD_W-LANES-1:0], ln_s2_r};
        // single-cycle sync restarts framing on this beat
        if (rs_s2_r && !rs_d_r) begin
          beat_nxt = 2'h1;
          sh_nxt = {{(WORD_W-LANES){1'b0}}, ln_s2_r};
        end else if (beat_r == 2'(WORD_BEATS - 1)) begin
          beat_nxt = '0;
          rvalid_nxt = 1'b1;
          rdata_nxt = {sh_r[WORD_W-LANES-1:0], ln_s2_r};
        end else begin
          beat_nxt = beat_r + 1'b1;
        end
      end
      // drive on falling edge so mac samples mid-bit on rising
      if (fall) begin
        if (tbeat_r == '0) begin
          f_pop = f_valid;
          tsh_nxt = f_valid ? f_data : '0;
          out_nxt = f_valid ? f_data[WORD_W-1 -: LANES] : '0;
        end else begin
          out_nxt = tsh_r[WORD_W-1-LANES*tbeat_r -: LANES];
        end
        tbeat_nxt = tbeat_r + 1'b1;
      end
    end
  end
  always_ff @(posedge clock_i) begin
    if (!nrst_i) begin
      st_r <= ST_RESET;
      div_r <= '0;
      clk_r <= 1'b0;
      rs_s1_r <= 1'b0;
      rs_s2_r <= 1'b0;
      rs_d_r <= 1'b0;
      ln_s1_r <= '0;
      ln_s2_r <= '0;
      beat_r <= '0;
      tbeat_r <= '0;
      sh_r <= '0;
      tsh_r <= '0;
      out_r <= '0;
      rvalid_r <= 1'b0;
      rdata_r <= '0;
      hi_r <= '0;
      hold_r <= '0;
      tx_ready_o <= 1'b0;
      link_reset_o <= 1'b1;
      powered_down_o <= 1'b0;
    end else if (ce_i) begin
      st_r <= st_nxt;
      div_r <= div_nxt;
      clk_r <= clk_nxt;
      rs_s1_r <= lnk.reset_sync_in;
      rs_s2_r <= rs_s1_r;
      if (rise) begin
        rs_d_r <= rs_s2_r;
      end
      ln_s1_r <= lnk.mac_to_phy_lane;
      ln_s2_r <= ln_s1_r;
      beat_r <= beat_nxt;
      tbeat_r <= tbeat_nxt;
      sh_r <= sh_nxt;
      tsh_r <= tsh_nxt;
      out_r <= out_nxt;
      rvalid_r <= rvalid_nxt;
      rdata_r <= rdata_nxt;
      hi_r <= hi_nxt;
      hold_r <= hold_nxt;
      tx_ready_o <= f_ready;
      link_reset_o <= st_nxt == ST_RESET;
      powered_down_o <= st_nxt == ST_DOWN;
    end
  end
  assign lnk.link_clock_out = clk_r;
  assign lnk.phy_to_mac_lane = out_r;
  assign rx_valid_o = rvalid_r;
  assign rx_data_o = rdata_r;
endmodule

// file: hw/mac_link_end.sv
// mac end of the narrow link: reset/sync requests and lane framing
`timescale 1ns/100ps
module mac_link_end
  import link_pkg::*;
#(
  parameter int RESET_HOLD = link_pkg::RESET_HOLD_CYC
) (
  // clock and reset
  input wire logic clock_i,
  input wire logic nrst_i,
  input wire logic ce_i,
  // link pins
  link_if.mac lnk,
  // user side
  input wire logic reset_req_i,
  input wire logic sync_req_i,
  input wire logic tx_valid_i,
  output logic tx_ready_o,
  input wire logic [link_pkg::WORD_W-1:0] tx_data_i,
  output logic rx_valid_o,
  output logic [link_pkg::WORD_W-1:0] rx_data_o,
  output logic busy_o
);
  import link_pkg::*;
  logic ck_s1_r, ck_s2_r, ck_d_r;
  logic [2:0] ln_s1_r, ln_s2_r;
  logic rs_r, rs_nxt, sync_pend_r, sync_pend_nxt;
  logic [31:0] hold_r, hold_nxt;
  logic [1:0] beat_r, beat_nxt, tbeat_r, tbeat_nxt;
  logic [WORD_W-1:0] sh_r, sh_nxt, tsh_r, tsh_nxt;
  logic [2:0] out_r, out_nxt;
  logic rvalid_r, rvalid_nxt, rise, fall;
  logic rx_arm_r, rx_arm_nxt;
  logic [WORD_W-1:0] rdata_r, rdata_nxt;
  assign rise = ck_s2_r && !ck_d_r;
  assign fall = !ck_s2_r && ck_d_r;
  always_comb begin
    rs_nxt = rs_r;
    hold_nxt = hold_r;
    sync_pend_nxt = sync_pend_r || sync_req_i;
    beat_nxt = beat_r;
    sh_nxt = sh_r;
    rvalid_nxt = 1'b0;
    rdata_nxt = rdata_r;
    tbeat_nxt = tbeat_r;
    tsh_nxt = tsh_r;
    out_nxt = out_r;
    tx_ready_o = 1'b0;
    rx_arm_nxt = rx_arm_r;
    if (hold_r != '0) begin
      hold_nxt = hold_r - 1'b1;
      rs_nxt = hold_r != 32'h1;
      tbeat_nxt = '0;
      beat_nxt = '0;
      rx_arm_nxt = 1'b0;
    end else if (reset_req_i) begin
      hold_nxt = 32'(RESET_HOLD);
      rs_nxt = 1'b1;
    end else if (fall) begin
      // drive sync and lanes on falling edge of the phy clock
      rx_arm_nxt = 1'b1;
      rs_nxt = sync_pend_r && tbeat_r == '0;
      if (rs_nxt) begin
        sync_pend_nxt = 1'b0;
      end
      if (tbeat_r == '0) begin
        tx_ready_o = tx_valid_i;
        tsh_nxt = tx_valid_i ? tx_data_i : '0;
        out_nxt = tx_valid_i ? tx_data_i[WORD_W-1 -: LANES] : '0;
      end else begin
        out_nxt = tsh_r[WORD_W-1-LANES*tbeat_r -: LANES];
      end
      tbeat_nxt = tbeat_r + 1'b1;
    end
    // first rise after a restart comes before beat 0 is driven
    if (rise && hold_r == '0 && rx_arm_r) begin
      sh_nxt = {sh_r[WORD_W-LANES-1:0], ln_s2_r};
      if (beat_r == 2'(WORD_BEATS - 1)) begin
        beat_nxt = '0;
        rvalid_nxt = 1'b1;
        rdata_nxt = {sh_r[WORD_W-LANES-1:0], ln_s2_r};
      end else begin
        beat_nxt = beat_r + 1'b1;
      end
    end
  end
  always_ff @(posedge clock_i) begin
    if (!nrst_i) begin
      ck_s1_r <= 1'b0;
      ck_s2_r <= 1'b0;
      ck_d_r <= 1'b0;
      ln_s1_r <= '0;
      ln_s2_r <= '0;
      rs_r <= 1'b0;
      sync_pend_r <= 1'b0;
      hold_r <= '0;
      beat_r <= '0;
      tbeat_r <= '0;
      sh_r <= '0;
      tsh_r <= '0;
      out_r <= '0;
      rvalid_r <= 1'b0;
      rx_arm_r <= 1'b0;
      rdata_r <= '0;
      busy_o <= 1'b0;
    end else if (ce_i) begin
      ck_s1_r <= lnk.link_clock_out;
      ck_s2_r <= ck_s1_r;
      ck_d_r <= ck_s2_r;
      ln_s1_r <= lnk.phy_to_mac_lane;
      ln_s2_r <= ln_s1_r;
      rs_r <= rs_nxt;
      sync_pend_r <= sync_pend_nxt;
      hold_r <= hold_nxt;
      beat_r <= beat_nxt;
      tbeat_r <= tbeat_nxt;
      sh_r <= sh_nxt;
      tsh_r <= tsh_nxt;
      out_r <= out_nxt;
      rvalid_r <= rvalid_nxt;
      rx_arm_r <= rx_arm_nxt;
      rdata_r <= rdata_nxt;
      busy_o <= hold_nxt != '0;
    end
  end
  assign lnk.reset_sync_in = rs_r;
  assign lnk.mac_to_phy_lane = out_r;
  assign rx_valid_o = rvalid_r;
  assign rx_data_o = rdata_r;
endmodule

// file: sim/link_props.sv
// assertion checker watching the narrow link pins between both ends
`timescale 1ns/100ps
module link_props
  import link_pkg::*;
#(
  parameter int RESET_HOLD = 200
) (
  // clock and reset
  input wire logic clock_i,
  input wire logic nrst_i,
  // phy controls
  input wire logic [1:0] speed_i,
  input wire logic power_down_i,
  // link pins
  input wire logic link_clock_out,
  input wire logic reset_sync_in,
  input wire logic [2:0] phy_to_mac_lane
);
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!nrst_i);
  // ----------------------------------------
  // helper counters
  // ----------------------------------------
  logic [15:0] rs_cnt_r, rs_cnt_nxt;
  logic [6:0] hi_cnt_r, hi_cnt_nxt, pd_cnt_r, pd_cnt_nxt;
  always_comb begin
    rs_cnt_nxt = reset_sync_in ? rs_cnt_r + 16'h1 : 16'h0;
    hi_cnt_nxt = link_clock_out ? hi_cnt_r + 7'h1 : 7'h0;
    // saturates so a long power-down cannot wrap
    pd_cnt_nxt = power_down_i ? pd_cnt_r + {6'h0, pd_cnt_r != 7'h64} : 7'h0;
  end
  always_ff @(posedge clock_i) begin
    if (!nrst_i) begin
      rs_cnt_r <= 16'h0;
      hi_cnt_r <= 7'h0;
      pd_cnt_r <= 7'h0;
    end else begin
      rs_cnt_r <= rs_cnt_nxt;
      hi_cnt_r <= hi_cnt_nxt;
      pd_cnt_r <= pd_cnt_nxt;
    end
  end
  // ----------------------------------------
  // properties
  // ----------------------------------------
  sequence s_long_release;
    rs_cnt_r > 16'h78 ##1 !reset_sync_in && !power_down_i;
  endsequence
  a_lanes_on_fall: assert property (
    $changed(phy_to_mac_lane) && !reset_sync_in && !power_down_i
    |-> !link_clock_out) else $error("phy lanes moved with clock high");
  a_gig_half: assert property (
    $rose(link_clock_out) && speed_i == SPEED_GIG && $stable(speed_i)
    |=> !link_clock_out) else $error("gigabit half period wrong");
  a_slow_period: assert property (
    $fell(link_clock_out) && speed_i == SPEED_10 && !power_down_i
    && rs_cnt_r == 16'h0 |-> hi_cnt_r == 7'(HALF_10))
    else $error("slow link clock high time wrong");
  a_clock_stopped: assert property (
    pd_cnt_r == 7'h64 |-> !link_clock_out)
    else $error("link clock runs in power-down");
  a_reset_hold: assert property (
    $fell(reset_sync_in) |-> rs_cnt_r <= 16'h50
    || rs_cnt_r >= 16'(RESET_HOLD)) else $error("reset released too soon");
  a_reset_stops: assert property (
    rs_cnt_r > 16'h78 |-> !link_clock_out)
    else $error("long reset did not stop link clock");
  a_idle_lanes: assert property (
    rs_cnt_r > 16'h78 |-> phy_to_mac_lane == 3'h0)
    else $error("phy lanes active during reset");
  a_wake_resume: assert property (
    s_long_release |-> ##[1:100] link_clock_out)
    else $error("link clock did not resume after reset");
endmodule

// file: sim/tb_top.sv
// self-checking bench joining the phy and mac ends of the link
`timescale 1ns/100ps
module tb_top;
  import link_pkg::*;
  localparam int HOLD = 200;
  logic clock_i = 1'b0;
  logic nrst_i = 1'b0;
  logic [1:0] speed_i = SPEED_100;
  logic power_down_i = 1'b0;
  logic p_valid = 1'b0;
  logic m_valid = 1'b0;
  logic reset_req = 1'b0;
  logic sync_req = 1'b0;
  logic ce = 1'b1;
  logic lvl;
  logic [2:0] lanes_seen;
  logic [WORD_W-1:0] p_data = 12'h000;
  logic [WORD_W-1:0] m_data = 12'h000;
  logic p_ready, m_ready, p_rx_v, m_rx_v, link_rst, pd_o, busy;
  logic [WORD_W-1:0] p_rx_d, m_rx_d;
  logic [WORD_W-1:0] exp_p[$], exp_m[$];
  logic saw_full = 1'b0;
  logic saw_lrst = 1'b0;
  logic [1:0] spd[3] = '{SPEED_GIG, SPEED_100, SPEED_10};
  int half[3] = '{HALF_GIG, HALF_100, HALF_10};
  int err_count = 0;
  int checks_done = 0;
  int seed = 2118;
  always #2.5 clock_i = ~clock_i;
  // ----------------------------------------
  // both ends and the checker
  // ----------------------------------------
  link_if link_if_i ();
  phy_link_end #(.RESET_HOLD(HOLD)) phy_link_end_i (
    .clock_i(clock_i), .nrst_i(nrst_i), .ce_i(ce), .lnk(link_if_i.phy),
    .speed_i(speed_i), .power_down_i(power_down_i), .tx_valid_i(p_valid),
    .tx_ready_o(p_ready), .tx_data_i(p_data), .rx_valid_o(p_rx_v),
    .rx_data_o(p_rx_d), .link_reset_o(link_rst), .powered_down_o(pd_o));
  mac_link_end #(.RESET_HOLD(HOLD)) mac_link_end_i (
    .clock_i(clock_i), .nrst_i(nrst_i), .ce_i(ce), .lnk(link_if_i.mac),
    .reset_req_i(reset_req), .sync_req_i(sync_req), .tx_valid_i(m_valid),
    .tx_ready_o(m_ready), .tx_data_i(m_data), .rx_valid_o(m_rx_v),
    .rx_data_o(m_rx_d), .busy_o(busy));
  link_props #(.RESET_HOLD(HOLD)) link_props_i (
    .clock_i(clock_i), .nrst_i(nrst_i), .speed_i(speed_i),
    .power_down_i(power_down_i),
    .link_clock_out(link_if_i.link_clock_out),
    .reset_sync_in(link_if_i.reset_sync_in),
    .phy_to_mac_lane(link_if_i.phy_to_mac_lane));
  // ----------------------------------------
  // compare and closing tasks
  // ----------------------------------------
  task automatic check_flag(input logic [15:0] e, input logic [15:0] g);
    checks_done++;
    if (g !== e) begin
      err_count++;
      $display("CHECK FAILED t=%0t exp=%h got=%h", $time, e, g);
    end
  endtask
  task automatic check_word(input logic [11:0] e, input logic [11:0] g);
    check_flag({4'h0, e}, {4'h0, g});
  endtask
  task automatic finish_test();
    if (err_count == 0 && checks_done > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  function automatic logic [WORD_W-1:0] rnd();
    // zero is reserved for idle words on the lanes
    return 12'($random(seed)) | 12'h001;
  endfunction
  // ----------------------------------------
  // drivers
  // ----------------------------------------
  task automatic phy_send(input logic [WORD_W-1:0] d);
    for (int i = 0; i < 4000 && p_ready !== 1'b1; i++) begin
      saw_full = 1'b1;
      @(negedge clock_i);
    end
    p_valid = 1'b1;
    p_data = d;
    exp_m.push_back(d);
    @(negedge clock_i);
    p_valid = 1'b0;
    // gap lets the late ready catch up with this push
    @(negedge clock_i);
  endtask
  task automatic mac_send(input logic [WORD_W-1:0] d);
    m_valid = 1'b1;
    m_data = d;
    #1;
    for (int i = 0; i < 4000 && m_ready !== 1'b1; i++) begin
      @(negedge clock_i);
      #1;
    end
    exp_p.push_back(d);
    @(negedge clock_i);
    m_valid = 1'b0;
    @(negedge clock_i);
  endtask
  task automatic wake(input logic [1:0] s);
    power_down_i = 1'b1;
    repeat (120) @(negedge clock_i);
    check_flag(16'(link_if_i.link_clock_out), 16'h0);
    check_flag(16'(pd_o), 16'h1);
    speed_i = s;
    power_down_i = 1'b0;
    saw_lrst = 1'b0;
    reset_req = 1'b1;
    @(negedge clock_i);
    reset_req = 1'b0;
    repeat (4) @(negedge clock_i);
    check_flag(16'(busy), 16'h1);
    for (int i = 0; i < 3000 && (busy !== 1'b0 || link_rst !== 1'b0); i++)
      @(negedge clock_i);
    check_flag(16'(busy), 16'h0);
    check_flag(16'(saw_lrst), 16'h1);
    check_flag(16'(link_rst), 16'h0);
  endtask
  task automatic period(input logic [15:0] e);
    realtime t0;
    @(posedge link_if_i.link_clock_out);
    t0 = $realtime;
    @(posedge link_if_i.link_clock_out);
    check_flag(16'(int'(($realtime - t0) / 5.0)), e);
    @(negedge clock_i);
  endtask
  // ----------------------------------------
  // scoreboard and sequence
  // ----------------------------------------
  always @(negedge clock_i) begin
    if (link_rst === 1'b1) saw_lrst = 1'b1;
    if (p_rx_v === 1'b1 && p_rx_d !== 12'h000)
      check_word(exp_p.size() ? exp_p.pop_front() : 12'h000, p_rx_d);
    if (m_rx_v === 1'b1 && m_rx_d !== 12'h000)
      check_word(exp_m.size() ? exp_m.pop_front() : 12'h000, m_rx_d);
  end
  initial begin
    repeat (6) @(negedge clock_i);
    nrst_i = 1'b1;
    repeat (2) @(negedge clock_i);
    foreach (spd[k]) begin
      wake(spd[k]);
      period(16'(2 * half[k]));
      // clock enable low must freeze the phy link clock and phy lanes
      if (k == 1) begin
        ce = 1'b0;
        lvl = link_if_i.link_clock_out;
        lanes_seen = link_if_i.phy_to_mac_lane;
        repeat (10) @(negedge clock_i);
        check_flag(16'(link_if_i.link_clock_out), 16'(lvl));
        check_flag(16'(link_if_i.phy_to_mac_lane), 16'(lanes_seen));
        ce = 1'b1;
      end
      sync_req = 1'b1;
      @(negedge clock_i);
      sync_req = 1'b0;
      repeat (200) @(negedge clock_i);
      check_flag(16'(link_rst), 16'h0);
      fork
        for (int i = 0; i < 6; i++) phy_send(rnd());
        for (int i = 0; i < 3; i++) mac_send(rnd());
      join
      for (int i = 0; i < 6000 && exp_p.size() + exp_m.size() > 0; i++)
        @(negedge clock_i);
      check_flag(16'(exp_p.size() + exp_m.size()), 16'h0);
    end
    check_flag(16'(saw_full), 16'h1);
    finish_test();
  end
  initial begin
    repeat (60000) @(negedge clock_i);
    err_count++;
    finish_test();
  end
endmodule
